//--- rtl/csdec_defs.svh
// Purpose: Constants for the chip-select address decoder
// Assumes: 32-bit byte address, 16-bit external bus
// Notes: Offsets, reset values and timing counts live here
//
// Functional notes
// - Eight selects form four pairs sharing base, size, wait states and width.
// - A pair's second region starts right after the first region ends.
// - SDRAM enable turns five selects into write enable, strobes and SDRAM selects.
// - After reset only pair A first select is active, carrying boot flash.
// - At reset flash answers at zero and mirrors everywhere below 0xFFFFF000 until pair A reprogrammed.
// - Flash accesses end after programmed wait states, no device acknowledge.
// - PCI bridge on pair B first select at 0x20000000, ends on bridge completion.
// - Ethernet on pair A second select, one byte register per word address.
// - Ethernet register block decodes from 0x10400000.
// - Working flash region decodes 0x10000000 through 0x103FFFFF.
// - Working SDRAM decodes from zero upward, up to 32 MB.
// - No external select answers from 0xFFFFF000 to the top.
// - SDRAM decode size comes from board straps, not registers.
`ifndef CSDEC_DEFS_SVH
`define CSDEC_DEFS_SVH

`define CSDEC_FLASH_BASE 32'h1000_0000
`define CSDEC_FLASH_SIZE_LOG2 22
`define CSDEC_ETH_BASE 32'h1040_0000
`define CSDEC_PCI_BASE 32'h2000_0000
`define CSDEC_PCI_SIZE_LOG2 17
`define CSDEC_SDRAM_BASE 32'h0000_0000
`define CSDEC_SDRAM_MAX_LOG2 25
`define CSDEC_ONCHIP_BASE 32'hFFFF_F000
`define CSDEC_RST_WAIT 4'hF
`define CSDEC_RST_WIDE 1'b1
`define CSDEC_RST_SIZE_LOG2 5'h16

`endif

//--- rtl/csdec_pkg.sv
// Purpose: Types for the chip-select address decoder
// Assumes: Used with csdec_defs.svh
// Notes: Pair indices and access states
package csdec_pkg;
    typedef enum logic [1:0] {
        CSDEC_PAIR_A,
        CSDEC_PAIR_B,
        CSDEC_PAIR_C,
        CSDEC_PAIR_D
    } csdec_pair_t;

    typedef enum logic [1:0] {
        CSDEC_IDLE,
        CSDEC_WAIT_INT,
        CSDEC_WAIT_EXT,
        CSDEC_DONE
    } csdec_state_t;
endpackage

//--- rtl/csdec_region.sv
// Purpose: Decode one pair of selects from shared base and size
// Assumes: Size is a power of two, base aligned to twice the size
// Notes: Second region follows the first with no gap
`timescale 1ns/100ps
`default_nettype none
module csdec_region #(
    parameter int AW = 32
) (
    // Address and pair setup
    input wire logic [AW-1:0] i_addr,
    input wire logic [AW-1:0] i_base,
    input wire logic [4:0] i_size_log2,
    input wire logic i_enable,
    // Decoded hits
    output logic o_hit_first,
    output logic o_hit_second
);
    logic [AW-1:0] mask_first;
    logic [AW-1:0] offs;

    // Region offset and the first select's span
    always_comb begin
        offs = i_addr - i_base;
        mask_first = ({AW{1'b1}} << i_size_log2);
    end

    // First region is [base, base+size), second is the next size bytes
    always_comb begin
        o_hit_first = i_enable && ((offs & mask_first) == '0);
        o_hit_second = i_enable && ((offs & (mask_first << 1)) == '0)
            && offs[i_size_log2];
    end
endmodule
`default_nettype wire

//--- rtl/csdec_top.sv
// Purpose: Chip-select and address decoder for the external bus
// Assumes: One access at a time, requests held until o_done
// Notes: Pair setup arrives as plain ports; no register bus
`timescale 1ns/100ps
`default_nettype none
`include "csdec_defs.svh"
module csdec_top
    import csdec_pkg::*;
#(
    parameter int AW = 32
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rstn,
    // Bus master access
    input wire logic i_req,
    input wire logic i_write,
    input wire logic [AW-1:0] i_addr,
    output logic o_done,
    output logic o_byte_lane_low,
    // Pair setup, index 0..3 for pairs A..D
    input wire logic [3:0] i_pair_load,
    input wire logic [AW-1:0] i_pair_base [4],
    input wire logic [4:0] i_pair_size_log2 [4],
    input wire logic [3:0] i_pair_wait [4],
    input wire logic [3:0] i_pair_ext [4],
    input wire logic [3:0] i_pair_wide,
    input wire logic i_sdram_en,
    // Board straps and device completion
    input wire logic [1:0] i_sdram_size_strap,
    input wire logic i_pci_ready,
    // Selects and SDRAM controls, active high
    output logic o_pair_a_first_select,
    output logic o_pair_a_second_select,
    output logic o_pair_b_first_select,
    output logic o_pair_b_second_select,
    output logic o_pair_c_first_select,
    output logic o_pair_c_second_select,
    output logic o_pair_d_first_select,
    output logic o_pair_d_second_select,
    output logic o_sdram_write_en,
    output logic o_sdram_row_strobe,
    output logic o_sdram_col_strobe,
    output logic [3:0] o_pair_programmed
);
    ////////////////////////////////////////////////////////////////////////////
    // Pair configuration state
    logic [AW-1:0] base_q [4];
    logic [AW-1:0] base_d [4];
    logic [4:0] size_q [4];
    logic [4:0] size_d [4];
    logic [3:0] wait_q [4];
    logic [3:0] wait_d [4];
    logic [3:0] ext_q;
    logic [3:0] ext_d;
    logic [3:0] wide_q;
    logic [3:0] wide_d;
    logic [3:0] prog_q;
    logic [3:0] prog_d;
    logic sdram_q;
    logic sdram_d;
    logic [1:0] strap_s1_q;
    logic [1:0] strap_s2_q;
    logic [1:0] strap_s3_q;
    logic [1:0] strap_q;
    logic [1:0] strap_d;
    logic pci_s1_q;
    logic pci_s2_q;
    logic pci_s3_q;
    logic pci_rdy_q;
    logic pci_rdy_d;

    // Next configuration: a load replaces the pair's setup
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            base_d[p] = i_pair_load[p] ? i_pair_base[p] : base_q[p];
            size_d[p] = i_pair_load[p] ? i_pair_size_log2[p] : size_q[p];
            wait_d[p] = i_pair_load[p] ? i_pair_wait[p] : wait_q[p];
        end
        ext_d = ext_q;
        wide_d = wide_q;
        for (int p = 0; p < 4; p++) begin
            if (i_pair_load[p]) begin
                ext_d[p] = i_pair_ext[p][0];
                wide_d[p] = i_pair_wide[p];
            end
        end
        prog_d = prog_q | i_pair_load;
        sdram_d = i_sdram_en;
        // Strap accepted once second and third stages agree
        strap_d = (strap_s2_q == strap_s3_q) ? strap_s3_q : strap_q;
        pci_rdy_d = (pci_s2_q == pci_s3_q) ? pci_s3_q : pci_rdy_q;
    end

    // Configuration registers; only pair A is usable after reset
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            for (int p = 0; p < 4; p++) begin
                base_q[p] <= '0;
                size_q[p] <= `CSDEC_RST_SIZE_LOG2;
                wait_q[p] <= `CSDEC_RST_WAIT;
            end
            ext_q <= 4'h0;
            wide_q <= {4{`CSDEC_RST_WIDE}};
            prog_q <= 4'h0;
            sdram_q <= 1'b0;
            strap_s1_q <= 2'h0;
            strap_s2_q <= 2'h0;
            strap_s3_q <= 2'h0;
            strap_q <= 2'h0;
            pci_s1_q <= 1'b0;
            pci_s2_q <= 1'b0;
            pci_s3_q <= 1'b0;
            pci_rdy_q <= 1'b0;
        end else begin
            base_q <= base_d;
            size_q <= size_d;
            wait_q <= wait_d;
            ext_q <= ext_d;
            wide_q <= wide_d;
            prog_q <= prog_d;
            sdram_q <= sdram_d;
            strap_s1_q <= i_sdram_size_strap;
            strap_s2_q <= strap_s1_q;
            strap_s3_q <= strap_s2_q;
            strap_q <= strap_d;
            pci_s1_q <= i_pci_ready;
            pci_s2_q <= pci_s1_q;
            pci_s3_q <= pci_s2_q;
            pci_rdy_q <= pci_rdy_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    logic [3:0] hit_first;
    logic [3:0] hit_second;
    logic onchip;
    logic sdram_hit;
    logic [4:0] sdram_log2;
    logic [7:0] sel_raw;

    // Per pair region comparators
    for (genvar g = 0; g < 4; g++) begin : g_pair
        csdec_region #(.AW(AW)) u_region (
            .i_addr(i_addr),
            .i_base(base_q[g]),
            .i_size_log2(size_q[g]),
            .i_enable(prog_q[g]),
            .o_hit_first(hit_first[g]),
            .o_hit_second(hit_second[g])
        );
    end

    // Select priorities: on-chip space, boot mirror, SDRAM, pairs
    always_comb begin
        onchip = (i_addr >= `CSDEC_ONCHIP_BASE);
        sdram_log2 = 5'(`CSDEC_SDRAM_MAX_LOG2 - 3) + {3'h0, strap_q};
        sdram_hit = sdram_q && ((i_addr >> sdram_log2) == '0);
        sel_raw = 8'h00;
        if (onchip) begin
            sel_raw = 8'h00;
        end else if (!prog_q[0]) begin
            sel_raw[0] = 1'b1;
        end else if (sdram_hit) begin
            sel_raw[6] = ~i_addr[sdram_log2 - 5'h01];
            sel_raw[7] = i_addr[sdram_log2 - 5'h01];
        end else begin
            sel_raw[0] = hit_first[0];
            sel_raw[1] = hit_second[0];
            sel_raw[2] = hit_first[1];
            sel_raw[3] = hit_second[1] && !sdram_q;
            sel_raw[4] = hit_first[2] && !sdram_q;
            sel_raw[5] = hit_second[2] && !sdram_q;
            sel_raw[6] = hit_first[3] && !sdram_q;
            sel_raw[7] = hit_second[3] && !sdram_q;
        end
        // Unimplemented space leaves sel_raw clear
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access sequencer
    csdec_state_t state_q;
    csdec_state_t state_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [7:0] sel_q;
    logic [7:0] sel_d;
    logic lane_q;
    logic lane_d;
    logic wr_q;
    logic wr_d;
    logic [1:0] pair_idx;

    // Pair of the first asserted select
    always_comb begin
        pair_idx = 2'h0;
        for (int s = 7; s >= 0; s--) begin
            if (sel_raw[s]) begin
                pair_idx = 2'(s / 2);
            end
        end
    end

    // Next access state
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        sel_d = sel_q;
        lane_d = lane_q;
        wr_d = wr_q;
        case (state_q)
            CSDEC_IDLE: begin
                if (i_req) begin
                    sel_d = sel_raw;
                    wr_d = i_write;
                    // Byte register sits in the low half of its word
                    lane_d = sel_raw[1] && wide_q[0];
                    cnt_d = wait_q[pair_idx];
                    if (sel_raw == 8'h00) begin
                        state_d = CSDEC_DONE;
                    end else if (ext_q[pair_idx] && !sdram_hit) begin
                        // Completion left over from the last cycle must clear first
                        cnt_d = 4'h1;
                        state_d = CSDEC_WAIT_EXT;
                    end else begin
                        state_d = CSDEC_WAIT_INT;
                    end
                end
            end
            CSDEC_WAIT_INT: begin
                if (cnt_q == 4'h0) begin
                    state_d = CSDEC_DONE;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            CSDEC_WAIT_EXT: begin
                if (!pci_rdy_q) begin
                    cnt_d = 4'h0;
                end else if (cnt_q == 4'h0) begin
                    state_d = CSDEC_DONE;
                end
            end
            CSDEC_DONE: begin
                sel_d = 8'h00;
                lane_d = 1'b0;
                wr_d = 1'b0;
                state_d = CSDEC_IDLE;
            end
            default: begin
                state_d = CSDEC_IDLE;
            end
        endcase
    end

    // Access state registers
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            state_q <= CSDEC_IDLE;
            cnt_q <= 4'h0;
            sel_q <= 8'h00;
            lane_q <= 1'b0;
            wr_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            sel_q <= sel_d;
            lane_q <= lane_d;
            wr_q <= wr_d;
        end
    end

    // Select outputs, with SDRAM reuse of five selects
    always_comb begin
        o_done = (state_q == CSDEC_DONE);
        o_byte_lane_low = lane_q;
        o_pair_a_first_select = sel_q[0];
        o_pair_a_second_select = sel_q[1];
        o_pair_b_first_select = sel_q[2];
        o_pair_b_second_select = sdram_q ? 1'b0 : sel_q[3];
        o_pair_c_first_select = sdram_q ? 1'b0 : sel_q[4];
        o_pair_c_second_select = sdram_q ? 1'b0 : sel_q[5];
        o_pair_d_first_select = sel_q[6];
        o_pair_d_second_select = sel_q[7];
        o_sdram_write_en = sdram_q && wr_q && (sel_q[7:6] != 2'h0);
        o_sdram_row_strobe = sdram_q && (state_q == CSDEC_WAIT_INT)
            && (sel_q[7:6] != 2'h0);
        o_sdram_col_strobe = sdram_q && (state_q == CSDEC_DONE)
            && (sel_q[7:6] != 2'h0);
        o_pair_programmed = prog_q;
    end
endmodule
`default_nettype wire

//--- tb/csdec_monitor.sv
// Purpose: Port-level checks of the chip-select decoder
// Assumes: Single clock, synchronous active-low reset
// Notes: Bound to csdec_top below the module
`timescale 1ns/100ps
`default_nettype none
module csdec_monitor #(
    parameter int AW = 32
) (
    // Clock, reset and access
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_req,
    input wire logic [AW-1:0] i_addr,
    input wire logic i_sdram_en,
    input wire logic i_pci_ready,
    // Observed outputs
    input wire logic o_done,
    input wire logic o_pair_a_first_select,
    input wire logic o_pair_a_second_select,
    input wire logic o_pair_b_first_select,
    input wire logic o_pair_b_second_select,
    input wire logic o_pair_c_first_select,
    input wire logic o_pair_c_second_select,
    input wire logic o_pair_d_first_select,
    input wire logic o_pair_d_second_select,
    input wire logic [3:0] o_pair_programmed,
    input wire logic o_sdram_write_en,
    input wire logic o_sdram_row_strobe,
    input wire logic o_sdram_col_strobe
);
    logic [7:0] sel;
    // All selects gathered, pair A first at the top
    assign sel = {o_pair_a_first_select, o_pair_a_second_select, o_pair_b_first_select,
                  o_pair_b_second_select, o_pair_c_first_select, o_pair_c_second_select,
                  o_pair_d_first_select, o_pair_d_second_select};
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rstn);
    ////////////////////////////////////////////////////////////////////////////////
    // Bridge completion seen while its select is up
    sequence pci_answer;
        $rose(i_pci_ready) ##0 o_pair_b_first_select;
    endsequence
    // Boot flash access starting before any pair A setup
    sequence boot_start;
        $rose(o_pair_a_first_select) ##0 !o_pair_programmed[0];
    endsequence
    done_pulse_a: assert property (o_done |=> !o_done)
        else $error("done held longer than one cycle");
    done_cause_a: assert property (o_done |-> $past(i_req))
        else $error("done without a request");
    onchip_quiet_a: assert property (o_done && i_addr >= 32'hFFFFF000 |-> sel == 8'h00)
        else $error("select raised in on-chip space");
    boot_mirror_a: assert property (o_done && !o_pair_programmed[0] && i_addr < 32'hFFFFF000
        |-> o_pair_a_first_select)
        else $error("boot mirror missed");
    single_select_a: assert property ($onehot0(sel))
        else $error("more than one select active");
    sdram_reuse_a: assert property (i_sdram_en && $past(i_sdram_en) |->
        !(o_pair_b_second_select || o_pair_c_first_select || o_pair_c_second_select))
        else $error("reused select driven in SDRAM mode");
    flash_bound_a: assert property (boot_start |-> ##16 o_done)
        else $error("boot flash wait count wrong");
    pci_finish_a: assert property (pci_answer |-> ##[5:6] o_done)
        else $error("bridge completion not honoured");
    strobe_order_a: assert property (o_sdram_col_strobe |-> $past(o_sdram_row_strobe))
        else $error("column strobe without row strobe before it");
    sdram_we_a: assert property (o_sdram_write_en |->
        (o_pair_d_first_select || o_pair_d_second_select))
        else $error("write enable without an SDRAM select");
endmodule
bind csdec_top csdec_monitor #(.AW(AW)) csdec_monitor_inst (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_req(i_req), .i_addr(i_addr),
    .i_sdram_en(i_sdram_en), .i_pci_ready(i_pci_ready), .o_done(o_done),
    .o_pair_a_first_select(o_pair_a_first_select), .o_pair_a_second_select(o_pair_a_second_select),
    .o_pair_b_first_select(o_pair_b_first_select), .o_pair_b_second_select(o_pair_b_second_select),
    .o_pair_c_first_select(o_pair_c_first_select), .o_pair_c_second_select(o_pair_c_second_select),
    .o_pair_d_first_select(o_pair_d_first_select), .o_pair_d_second_select(o_pair_d_second_select),
    .o_pair_programmed(o_pair_programmed), .o_sdram_write_en(o_sdram_write_en),
    .o_sdram_row_strobe(o_sdram_row_strobe), .o_sdram_col_strobe(o_sdram_col_strobe));
`default_nettype wire

//--- tb/csdec_bridge_model.sv
// Purpose: Behavioural bus bridge answering externally timed cycles
// Assumes: Select is active high and held until the cycle ends
// Notes: Delay is set by the bench, prompt or slow
`timescale 1ns/100ps
`default_nettype none
module csdec_bridge_model (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rstn,
    // Select and commanded delay
    input wire logic i_select,
    input wire logic [7:0] i_delay,
    // Completion
    output logic o_ready
);
    logic [7:0] cnt_q;
    // Raise completion after the delay, withdraw it once the select drops
    always_ff @(posedge i_mclk) begin
        if (!i_rstn || !i_select) begin
            cnt_q <= 8'h00;
            o_ready <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 8'h01;
            o_ready <= o_ready | (cnt_q == i_delay);
        end
    end
endmodule
`default_nettype wire

//--- tb/tb.sv
// Purpose: Self-checking bench for the chip-select decoder
// Assumes: One access at a time, request held until done
// Notes: Select result compressed to 7 bits, both pair D selects as one
`timescale 1ns/100ps
`default_nettype none
module tb;
    import csdec_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_req = 1'b0;
    logic i_write = 1'b0;
    logic [31:0] i_addr = 32'h00000000;
    logic [3:0] i_pair_load = 4'h0;
    logic [31:0] i_pair_base [4] = '{default: 32'h00000000};
    logic [4:0] i_pair_size_log2 [4] = '{default: 5'h16};
    logic [3:0] i_pair_wait [4] = '{default: 4'hF};
    logic [3:0] i_pair_ext [4] = '{default: 4'h0};
    logic [3:0] i_pair_wide = 4'hF;
    logic i_sdram_en = 1'b0;
    logic [1:0] i_sdram_size_strap = 2'h3;
    logic [7:0] pci_delay = 8'h00;
    logic pci_ready;
    logic o_done;
    logic [3:0] o_pair_programmed;
    wire logic [7:0] sel;
    logic [6:0] exp_q [$];
    logic o_byte_lane_low;
    logic o_sdram_write_en;
    logic o_sdram_row_strobe;
    logic o_sdram_col_strobe;
    logic [2:0] ctl_q [$];
    int compares = 0;
    int mismatches = 0;
    // Clock
    always #2.5 i_mclk = ~i_mclk;
    csdec_top csdec_top_inst (
        .i_mclk(i_mclk), .i_rstn(i_rstn), .i_req(i_req), .i_write(i_write), .i_addr(i_addr),
        .o_done(o_done), .o_byte_lane_low(o_byte_lane_low), .i_pair_load(i_pair_load),
        .i_pair_base(i_pair_base), .i_pair_size_log2(i_pair_size_log2),
        .i_pair_wait(i_pair_wait), .i_pair_ext(i_pair_ext), .i_pair_wide(i_pair_wide),
        .i_sdram_en(i_sdram_en), .i_sdram_size_strap(i_sdram_size_strap),
        .i_pci_ready(pci_ready), .o_pair_a_first_select(sel[7]),
        .o_pair_a_second_select(sel[6]), .o_pair_b_first_select(sel[5]),
        .o_pair_b_second_select(sel[4]), .o_pair_c_first_select(sel[3]),
        .o_pair_c_second_select(sel[2]), .o_pair_d_first_select(sel[1]),
        .o_pair_d_second_select(sel[0]), .o_sdram_write_en(o_sdram_write_en),
        .o_sdram_row_strobe(o_sdram_row_strobe), .o_sdram_col_strobe(o_sdram_col_strobe),
        .o_pair_programmed(o_pair_programmed));
    csdec_bridge_model csdec_bridge_model_inst (
        .i_mclk(i_mclk), .i_rstn(i_rstn), .i_select(sel[5]), .i_delay(pci_delay),
        .o_ready(pci_ready));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check_sel(input logic [6:0] exp, input logic [6:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    // Byte lane, SDRAM write enable and column strobe at completion
    task automatic check_ctl(input logic [2:0] exp, input logic [2:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t ctl exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic wrap_up;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One access: note the expected selects, hold the request until done
    task automatic access(input logic [31:0] addr, input logic [6:0] exp);
        int n;
        n = 0;
        @(negedge i_mclk);
        i_req = 1'b1;
        i_addr = addr;
        i_write = 1'($urandom);
        exp_q.push_back(exp);
        ctl_q.push_back({exp == 7'h20, i_write && i_sdram_en && exp[0], i_sdram_en && exp[0]});
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_done !== 1'b1 && n < 300);
        if (n >= 300)
            mismatches++;
        @(negedge i_mclk);
        i_req = 1'b0;
    endtask
    task automatic load(input int p, input logic [31:0] b, input logic [4:0] s,
                        input logic [3:0] w, input logic [3:0] e);
        @(negedge i_mclk);
        i_pair_base[p] = b;
        i_pair_size_log2[p] = s;
        i_pair_wait[p] = w;
        i_pair_ext[p] = e;
        i_pair_load[p] = 1'b1;
        @(negedge i_mclk);
        i_pair_load = 4'h0;
    endtask
    // Result watcher: each finished access takes the oldest note
    always @(posedge i_mclk) begin
        if (o_done === 1'b1 && exp_q.size() > 0)
            check_sel(exp_q.pop_front(), {sel[7:2], |sel[1:0]});
        if (o_done === 1'b1 && ctl_q.size() > 0)
            check_ctl(ctl_q.pop_front(),
                      {o_byte_lane_low, o_sdram_write_en, o_sdram_col_strobe});
    end
    // Watchdog
    initial begin
        #100000;
        mismatches++;
        wrap_up();
    end
    // Main sequence
    initial begin
        logic [31:0] r;
        void'($urandom(88));
        repeat (6) @(negedge i_mclk);
        i_rstn = 1'b1;
        repeat (4) @(negedge i_mclk);
        r = $urandom % 32'hFFFFF000;
        access(32'h00000000, 7'h40);
        access(r, 7'h40);
        access(32'hFFFFF000 | ($urandom & 32'h00000FFE), 7'h00);
        $display("boot mirror test done");
        load(0, 32'h10000000, 5'h16, 4'h2, 4'h0);
        load(1, 32'h20000000, 5'h11, 4'h0, 4'h1);
        load(3, 32'h00000000, 5'h18, 4'h1, 4'h0);
        access(32'h10000000, 7'h40);
        access(32'h103FFFFE, 7'h40);
        access(32'h10400000, 7'h20);
        access(32'h107FFFFE, 7'h20);
        access(32'h10800000, 7'h00);
        access(32'h20000000, 7'h10);
        pci_delay = 8'h28;
        access(32'h2001FFFE, 7'h10);
        access(32'hFFFFFFFE, 7'h00);
        $display("working map test done");
        i_sdram_en = 1'b1;
        access(32'h00000100, 7'h01);
        access(32'h01FFFFFE, 7'h01);
        i_sdram_size_strap = 2'h0;
        repeat (8) @(negedge i_mclk);
        access(32'h01000000, 7'h00);
        access(32'h003FFFFE, 7'h01);
        $display("sdram test done");
        wrap_up();
    end
endmodule
`default_nettype wire
